/* File: rtl/ssf_params.svh */
// Register map, field positions and counts of the serial status flags
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH

// Byte offsets
`define SSF_OFF_CTRL1   5'h00
`define SSF_OFF_CTRL2   5'h04
`define SSF_OFF_STATUS  5'h08
`define SSF_OFF_CTRL3   5'h0c
`define SSF_OFF_DATA    5'h10

// Status bit positions
`define SSF_S_TX_BUFFER_EMPTY_FLAG      7
`define SSF_S_TC        6
`define SSF_S_RX_BUFFER_FULL_FLAG      5
`define SSF_S_IDLE      4
`define SSF_S_OR        3
`define SSF_S_NF        2
`define SSF_S_FE        1
`define SSF_S_PF        0

// Control one fields
`define SSF_C1_M        4
`define SSF_C1_ILT      2
`define SSF_C1_PE       1

// Control two fields
`define SSF_C2_TX_DONE_IRQ_EN     6
`define SSF_C2_RIE      5
`define SSF_C2_TE       3
`define SSF_C2_SBK      0

// Control three fields
`define SSF_C3_R8       7
`define SSF_C3_T8       6

// Reset values, idle character lengths and the noise/parity bits armed on every status read
`define SSF_STATUS_RST  8'hc0
`define SSF_IDLE_BITS8  4'ha
`define SSF_IDLE_BITS9  4'hb
`define SSF_NOISE_PF    8'h05

`endif

/* File: rtl/ssf_pkg.sv */
// Types shared by the serial status flag logic
package ssf_pkg;

    // One received character from the receive shifter
    typedef struct packed {
        logic       done;
        logic       noise;
        logic       frameErr;
        logic       parityBad;
        logic [8:0] data;
    } ssf_rx_t;

endpackage

/* File: rtl/ssf_status_flags.sv */
// Status flags, clearing sequences and register bank of a serial port
//
// What this block does
// [RULE1] Buffer-empty set at reset and shifter load
// [RULE2] Buffer-empty cleared by status read, data write
// [RULE3] Complete set when buffer empty, nothing sending
// [RULE4] Complete cleared by read then write/preamble/break
// [RULE5] Receive-full set on character transfer
// [RULE6] Eight-bit: status read then data read clears
// [RULE7] Nine-bit: needs data and control three reads
// [RULE8] Idle set after full character of high
// [RULE9] Select zero: idle count starts after start
// [RULE10] Select one: idle count starts after stop
// [RULE11] Idle cleared by status then data read
// [RULE12] Idle rearmed only by a new character
// [RULE13] Overrun set, new character and errors dropped
// [RULE14] Overrun cleared by status then data read
// [RULE15] Noise flag set together with receive-full
// [RULE16] Noise cleared by status then data read
// [RULE17] Framing error set with receive-full
// [RULE18] Framing error cleared by status, data read
// [RULE19] Parity error only when parity enabled
// [RULE20] Parity error cleared by status, data read
// [RULE21] Status is read-only, writes ignored
// [RULE22] Receive interrupt while full and enabled
// [RULE23] Complete interrupt while set and enabled
`include "ssf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ssf_status_flags (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Avalon-MM slave
    input  wire logic [4:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    // Transmitter
    input  wire logic             txTake,
    input  wire logic             txActive,
    output logic      [8:0]       txData,
    output logic                  txBufEmpty,
    output logic                  txEnable,
    output logic                  breakReq,
    output logic                  preambleReq,
    // Receiver
    input  wire ssf_pkg::ssf_rx_t rxEvt,
    input  wire logic             rxStartBit,
    input  wire logic             rxStopBit,
    input  wire logic             bitTick,
    input  wire logic             rxPin,
    output logic                  nineBitMode,
    output logic                  parityEnable,
    // Interrupt requests
    output logic                  rxFullIrq,
    output logic                  txDoneIrq
);

    //--------------------------------------------------------------
    // Decode helpers
    //--------------------------------------------------------------
    function automatic logic isReg(input logic [4:0] a, input logic [4:0] off);
        isReg = (a[4:2] == off[4:2]);
    endfunction

    logic       waitReq_r;
    logic [31:0] readData_r;
    logic       tx_buffer_empty_flag_r, tc_r, rx_buffer_full_flag_r, idle_r, or_r, nf_r, fe_r, pf_r;
    logic [7:0] arm_r;
    logic       gotData_r, gotC3_r;
    logic       mode9_r, ilt_r, pe_r, tx_done_irq_en_r, rie_r, te_r, sbk_r;
    logic       t8_r, preamble_r;
    logic [8:0] txData_r, rxData_r;
    logic       pinMeta_r, pinSync_r;
    logic       countOn_r, idleArm_r;
    logic [3:0] idleCnt_r;
    logic       rxIrq_r, tcIrq_r;

    logic [7:0] statusVal;
    logic       acc, rdAcc, wrAcc;
    logic       dataWr, dataRd, c3Rd, statRd, teRise, sbkSet;
    logic       clrTdre, clrTc, clrRdrf, clrRx;
    logic       rdrfSet, tcSet, idleHit;
    logic [3:0] idleLen;

    assign statusVal = {tx_buffer_empty_flag_r, tc_r, rx_buffer_full_flag_r, idle_r, or_r, nf_r, fe_r, pf_r};

    //--------------------------------------------------------------
    // Bus slave: one wait cycle, then the answer
    //--------------------------------------------------------------
    assign acc    = (avs_read | avs_write) & ~waitReq_r;
    assign rdAcc  = acc & avs_read;
    assign wrAcc  = acc & avs_write & avs_byteenable[0];
    assign dataWr = wrAcc & isReg(avs_address, `SSF_OFF_DATA);
    assign dataRd = rdAcc & isReg(avs_address, `SSF_OFF_DATA);
    assign c3Rd   = rdAcc & isReg(avs_address, `SSF_OFF_CTRL3);
    assign statRd = rdAcc & isReg(avs_address, `SSF_OFF_STATUS);
    assign teRise = wrAcc & isReg(avs_address, `SSF_OFF_CTRL2)
                    & avs_writedata[`SSF_C2_TE] & ~te_r;
    assign sbkSet = wrAcc & isReg(avs_address, `SSF_OFF_CTRL2)
                    & avs_writedata[`SSF_C2_SBK];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            waitReq_r <= 1'b1;
        end else begin
            waitReq_r <= ~((avs_read | avs_write) & waitReq_r);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            readData_r <= 32'h0;
        end else if (avs_read && waitReq_r) begin
            readData_r <= 32'h0;
            if (isReg(avs_address, `SSF_OFF_CTRL1)) begin
                readData_r[`SSF_C1_M]   <= mode9_r;
                readData_r[`SSF_C1_ILT] <= ilt_r;
                readData_r[`SSF_C1_PE]  <= pe_r;
            end else if (isReg(avs_address, `SSF_OFF_CTRL2)) begin
                readData_r[`SSF_C2_TX_DONE_IRQ_EN] <= tx_done_irq_en_r;
                readData_r[`SSF_C2_RIE]  <= rie_r;
                readData_r[`SSF_C2_TE]   <= te_r;
                readData_r[`SSF_C2_SBK]  <= sbk_r;
            end else if (isReg(avs_address, `SSF_OFF_STATUS)) begin
                readData_r[7:0] <= statusVal;
            end else if (isReg(avs_address, `SSF_OFF_CTRL3)) begin
                readData_r[`SSF_C3_R8] <= rxData_r[8];
                readData_r[`SSF_C3_T8] <= t8_r;
            end else if (isReg(avs_address, `SSF_OFF_DATA)) begin
                readData_r[7:0] <= rxData_r[7:0];
            end
        end
    end

    //--------------------------------------------------------------
    // Control registers (status offset takes no write)
    //--------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode9_r <= 1'b0;
            ilt_r   <= 1'b0;
            pe_r    <= 1'b0;
            tx_done_irq_en_r  <= 1'b0;
            rie_r   <= 1'b0;
            te_r    <= 1'b0;
            sbk_r   <= 1'b0;
            t8_r    <= 1'b0;
        end else if (wrAcc) begin // [RULE21]
            if (isReg(avs_address, `SSF_OFF_CTRL1)) begin
                mode9_r <= avs_writedata[`SSF_C1_M];
                ilt_r   <= avs_writedata[`SSF_C1_ILT];
                pe_r    <= avs_writedata[`SSF_C1_PE];
            end
            if (isReg(avs_address, `SSF_OFF_CTRL2)) begin
                tx_done_irq_en_r <= avs_writedata[`SSF_C2_TX_DONE_IRQ_EN];
                rie_r  <= avs_writedata[`SSF_C2_RIE];
                te_r   <= avs_writedata[`SSF_C2_TE];
                sbk_r  <= avs_writedata[`SSF_C2_SBK];
            end
            if (isReg(avs_address, `SSF_OFF_CTRL3)) begin
                t8_r <= avs_writedata[`SSF_C3_T8];
            end
        end
    end

    //--------------------------------------------------------------
    // Clearing sequences: status read arms, later access clears
    //--------------------------------------------------------------
    assign clrTdre = arm_r[`SSF_S_TX_BUFFER_EMPTY_FLAG] & dataWr; // [RULE2]
    assign clrTc   = arm_r[`SSF_S_TC] & (dataWr | teRise | sbkSet); // [RULE4]
    assign clrRx   = dataRd;
    assign clrRdrf = arm_r[`SSF_S_RX_BUFFER_FULL_FLAG] & (mode9_r
                     ? ((dataRd | gotData_r) & (c3Rd | gotC3_r)) // [RULE7]
                     : dataRd); // [RULE6]

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            arm_r     <= 8'h0;
            gotData_r <= 1'b0;
            gotC3_r   <= 1'b0;
        end else if (statRd) begin
            arm_r     <= readData_r[7:0] | `SSF_NOISE_PF;
            gotData_r <= 1'b0;
            gotC3_r   <= 1'b0;
        end else begin
            if (clrTdre) arm_r[`SSF_S_TX_BUFFER_EMPTY_FLAG] <= 1'b0;
            if (clrTc)   arm_r[`SSF_S_TC]   <= 1'b0;
            if (clrRdrf) arm_r[`SSF_S_RX_BUFFER_FULL_FLAG] <= 1'b0;
            if (clrRx) begin
                arm_r[4:0] <= 5'h0;
            end
            gotData_r <= ~clrRdrf & (gotData_r | dataRd);
            gotC3_r   <= ~clrRdrf & (gotC3_r | c3Rd);
        end
    end

    //--------------------------------------------------------------
    // Transmit side flags
    //--------------------------------------------------------------
    assign tcSet = tx_buffer_empty_flag_r & ~clrTdre & ~txActive & ~preamble_r & ~sbk_r
                   & ~teRise & ~sbkSet & ~dataWr;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_buffer_empty_flag_r <= 1'(`SSF_STATUS_RST >> `SSF_S_TX_BUFFER_EMPTY_FLAG);
        end else if (txTake) begin
            tx_buffer_empty_flag_r <= 1'b1; // [RULE1]
        end else if (clrTdre) begin
            tx_buffer_empty_flag_r <= 1'b0; // [RULE2]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tc_r <= 1'(`SSF_STATUS_RST >> `SSF_S_TC);
        end else if (tcSet) begin
            tc_r <= 1'b1; // [RULE3]
        end else if (clrTc) begin
            tc_r <= 1'b0; // [RULE4]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            txData_r   <= 9'h0;
            preamble_r <= 1'b0;
        end else begin
            if (dataWr) begin
                txData_r <= {t8_r, avs_writedata[7:0]};
            end
            if (teRise) begin
                preamble_r <= 1'b1;
            end else if (txActive) begin
                preamble_r <= 1'b0;
            end
        end
    end

    //--------------------------------------------------------------
    // Receive side flags
    //--------------------------------------------------------------
    assign rdrfSet = rxEvt.done & ~rx_buffer_full_flag_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_buffer_full_flag_r   <= 1'b0;
            nf_r     <= 1'b0;
            fe_r     <= 1'b0;
            pf_r     <= 1'b0;
            rxData_r <= 9'h0;
        end else if (rdrfSet) begin
            rx_buffer_full_flag_r   <= 1'b1; // [RULE5]
            nf_r     <= rxEvt.noise; // [RULE15]
            fe_r     <= rxEvt.frameErr; // [RULE17]
            pf_r     <= rxEvt.parityBad & pe_r; // [RULE19]
            rxData_r <= rxEvt.data;
        end else begin
            if (clrRdrf) rx_buffer_full_flag_r <= 1'b0;
            if (clrRx && arm_r[`SSF_S_NF]) nf_r <= 1'b0; // [RULE16]
            if (clrRx && arm_r[`SSF_S_FE]) fe_r <= 1'b0; // [RULE18]
            if (clrRx && arm_r[`SSF_S_PF]) pf_r <= 1'b0; // [RULE20]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            or_r <= 1'b0;
        end else if (rxEvt.done && rx_buffer_full_flag_r) begin
            or_r <= 1'b1; // [RULE13]
        end else if (clrRx && arm_r[`SSF_S_OR]) begin
            or_r <= 1'b0; // [RULE14]
        end
    end

    //--------------------------------------------------------------
    // Idle line detection
    //--------------------------------------------------------------
    assign idleLen = mode9_r ? `SSF_IDLE_BITS9 : `SSF_IDLE_BITS8; // [RULE8]
    assign idleHit = countOn_r & bitTick & pinSync_r & (idleCnt_r + 4'h1 == idleLen);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_r <= 1'b1;
            pinSync_r <= 1'b1;
        end else begin
            pinMeta_r <= rxPin;
            pinSync_r <= pinMeta_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            countOn_r <= 1'b0;
            idleCnt_r <= 4'h0;
        end else if ((rxStartBit && !ilt_r) || (rxStopBit && ilt_r)) begin
            countOn_r <= 1'b1; // [RULE9] [RULE10]
            idleCnt_r <= 4'h0;
        end else if (idleHit) begin
            countOn_r <= 1'b0;
            idleCnt_r <= 4'h0;
        end else if (countOn_r && bitTick) begin
            idleCnt_r <= pinSync_r ? idleCnt_r + 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idleArm_r <= 1'b0;
            idle_r    <= 1'b0;
        end else begin
            if (rdrfSet) begin
                idleArm_r <= 1'b1; // [RULE12]
            end else if (idleHit) begin
                idleArm_r <= 1'b0;
            end
            if (idleHit && idleArm_r) begin
                idle_r <= 1'b1; // [RULE8]
            end else if (clrRx && arm_r[`SSF_S_IDLE]) begin
                idle_r <= 1'b0; // [RULE11]
            end
        end
    end

    //--------------------------------------------------------------
    // Interrupt requests
    //--------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxIrq_r <= 1'b0;
            tcIrq_r <= 1'b0;
        end else begin
            rxIrq_r <= rx_buffer_full_flag_r & rie_r; // [RULE22]
            tcIrq_r <= tc_r & tx_done_irq_en_r; // [RULE23]
        end
    end

    assign avs_readdata    = readData_r;
    assign avs_waitrequest = waitReq_r;
    assign txData          = txData_r;
    assign txBufEmpty      = tx_buffer_empty_flag_r;
    assign txEnable        = te_r;
    assign breakReq        = sbk_r;
    assign preambleReq     = preamble_r;
    assign nineBitMode     = mode9_r;
    assign parityEnable    = pe_r;
    assign rxFullIrq       = rxIrq_r;
    assign txDoneIrq       = tcIrq_r;

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_tx_buffer_empty_flag_take: assert property (txTake |=> tx_buffer_empty_flag_r) // [RULE1]
        else $error("buffer empty not set on shifter load");
    a_tx_buffer_empty_flag_clear: assert property ($fell(tx_buffer_empty_flag_r) |-> $past(arm_r[7] && dataWr)) // [RULE2]
        else $error("buffer empty cleared without sequence");
    a_tc_idle: assert property (tcSet |=> tc_r) // [RULE3]
        else $error("complete flag not set when idle");
    a_tc_clear: assert property ($fell(tc_r) |-> $past(arm_r[6])) // [RULE4]
        else $error("complete flag cleared without status read");
    a_rx_buffer_full_flag_set: assert property (rxEvt.done |=> rx_buffer_full_flag_r) // [RULE5]
        else $error("receive full not set");
    a_rx_buffer_full_flag_eight: assert property (!mode9_r && $fell(rx_buffer_full_flag_r) |-> $past(dataRd)) // [RULE6]
        else $error("eight-bit clear without data read");
    a_rx_buffer_full_flag_nine: assert property (mode9_r && $fell(rx_buffer_full_flag_r) |-> $past(dataRd || c3Rd)) // [RULE7]
        else $error("nine-bit clear without data or control read");
    a_ovr_drop: assert property (rxEvt.done && rx_buffer_full_flag_r |=> or_r && $stable(rxData_r)) // [RULE13]
        else $error("overrun not flagged or data replaced");
    a_fe_with_full: assert property ($rose(fe_r) |-> $rose(rx_buffer_full_flag_r)) // [RULE17]
        else $error("framing error set apart from receive full");
    a_pf_gated: assert property (!pe_r && rdrfSet |=> !pf_r) // [RULE19]
        else $error("parity error with parity disabled");
    a_idle_once: assert property ($rose(idle_r) |-> $past(idleArm_r)) // [RULE12]
        else $error("idle set without new character");
    a_irq_rx: assert property (rx_buffer_full_flag_r && rie_r |=> rxFullIrq) // [RULE22]
        else $error("receive interrupt missing");
    a_irq_tc: assert property (txDoneIrq |-> $past(tc_r && tx_done_irq_en_r)) // [RULE23]
        else $error("complete interrupt without cause");
    a_bus_answer: assert property ((avs_read || avs_write) && waitReq_r |=> !avs_waitrequest)
        else $error("bus answer late");

    c_overrun: cover property (rxEvt.done && rx_buffer_full_flag_r);
    c_idle: cover property ($rose(idle_r));
    c_preamble: cover property (clrTc && teRise);
    c_nine_clear: cover property (mode9_r && clrRdrf);

endmodule

`default_nettype wire

/* File: tb/ssf_far_model.sv */
// Far-side model: transmit shifter and receive front end
`timescale 1ns/1ps
`default_nettype none

module ssf_far_model (
    // Clock
    input  wire logic            sys_clk,
    // Transmit side
    input  wire logic            txBufEmpty,
    input  wire logic            breakReq,
    input  wire logic            preambleReq,
    output var logic             txTake,
    output var logic             txActive,
    // Receive side
    output var ssf_pkg::ssf_rx_t rxEvt,
    output var logic             rxStartBit,
    output var logic             rxStopBit,
    output logic                 bitTick,
    output var logic             rxPin
);
    bit [2:0] tickCnt_r;

    // Bit time of eight clocks
    always_ff @(posedge sys_clk) begin
        tickCnt_r <= tickCnt_r + 3'h1;
    end
    assign bitTick = (tickCnt_r == 3'h7);

    // Shifter takes a full buffer, then sends for a while
    initial begin
        txTake = 1'b0;
        txActive = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (txBufEmpty === 1'b0) begin
                repeat (6) @(posedge sys_clk);
                txTake <= 1'b1;
                txActive <= 1'b1;
                @(posedge sys_clk);
                txTake <= 1'b0;
                repeat (30) @(posedge sys_clk);
                txActive <= 1'b0;
            end else if (preambleReq === 1'b1 || breakReq === 1'b1) begin
                txActive <= 1'b1;
                @(posedge sys_clk);
                while (breakReq === 1'b1) @(posedge sys_clk);
                repeat (20) @(posedge sys_clk);
                txActive <= 1'b0;
            end
        end
    end

    initial begin
        rxEvt = 13'h0000;
        rxStartBit = 1'b0;
        rxStopBit = 1'b0;
        rxPin = 1'b1;
    end

    task automatic tick_wait();
        @(posedge sys_clk);
        while (bitTick !== 1'b1) @(posedge sys_clk);
    endtask

    // One frame; character handed over at the end of the stop bit
    task automatic send_char(input logic [8:0] d, input logic nz, input logic fe,
                             input logic pb, input logic nine);
        tick_wait();
        rxPin <= 1'b0;
        rxStartBit <= 1'b1;
        @(posedge sys_clk);
        rxStartBit <= 1'b0;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            tick_wait();
            rxPin <= d[i];
        end
        tick_wait();
        rxPin <= ~fe;
        tick_wait();
        rxStopBit <= 1'b1;
        rxEvt <= {1'b1, nz, fe, pb, d};
        @(posedge sys_clk);
        rxStopBit <= 1'b0;
        rxEvt <= {1'b0, ~nz, ~fe, ~pb, ~d};
        rxPin <= 1'b1;
    endtask
endmodule

`default_nettype wire

/* File: tb/ssf_status_flags_tb.sv */
// Self-checking bench of the serial status flags
`include "ssf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ssf_status_flags_tb;
    logic             sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [4:0]       avs_address;
    logic [31:0]      avs_writedata, avs_readdata;
    logic [3:0]       avs_byteenable;
    logic             txTake, txActive, txBufEmpty, txEnable, breakReq, preambleReq;
    logic [8:0]       txData, d;
    ssf_pkg::ssf_rx_t rxEvt;
    logic             rxStartBit, rxStopBit, bitTick, rxPin;
    logic             nineBitMode, parityEnable, rxFullIrq, txDoneIrq;
    logic [7:0]       expQ[$];
    logic [7:0]       e;
    logic [2:0]       f;
    logic [31:0]      seed;
    int               nMismatch;
    int               checksDone;

    ssf_status_flags i_ssf_status_flags (.sys_clk, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .txTake, .txActive, .txData, .txBufEmpty, .txEnable, .breakReq, .preambleReq,
        .rxEvt, .rxStartBit, .rxStopBit, .bitTick, .rxPin, .nineBitMode, .parityEnable,
        .rxFullIrq, .txDoneIrq);
    ssf_far_model i_ssf_far_model (.sys_clk, .txBufEmpty, .breakReq, .preambleReq,
        .txTake, .txActive, .rxEvt, .rxStartBit, .rxStopBit, .bitTick, .rxPin);

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        checksDone++;
        if (g !== ex) begin
            nMismatch++;
            $display("BAD %s expected %h seen %h", nm, ex, g);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Read results taken off the queue at the completion edge
    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            chk("readdata", {24'h0, expQ.pop_front()}, avs_readdata);
        end
    end

    task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, v};
        avs_write <= w;
        avs_read <= ~w;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        if (n >= 50) begin
            nMismatch++;
            $display("BAD waitrequest expected 0 seen 1");
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        bus(a, 1'b1, v);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] ex);
        expQ.push_back(ex);
        bus(a, 1'b0, 8'h00);
    endtask

    // Idle rises once after a character, then stays away
    task automatic settle(input logic [7:0] v);
        repeat (150) @(posedge sys_clk);
        rd(`SSF_OFF_STATUS, 8'hd0);
        rd(`SSF_OFF_DATA, v);
        rd(`SSF_OFF_STATUS, 8'hc0);
        repeat (150) @(posedge sys_clk);
        rd(`SSF_OFF_STATUS, 8'hc0);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        nMismatch++;
        print_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h1;
        seed = 32'h0883;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`SSF_OFF_STATUS, 8'hc0);
        wr(`SSF_OFF_STATUS, 8'h00);
        rd(`SSF_OFF_STATUS, 8'hc0);
        rd(5'h14, 8'h00);
        wr(`SSF_OFF_DATA, 8'h11);
        rd(`SSF_OFF_STATUS, 8'h00);
        seed = lfsr(seed);
        wr(`SSF_OFF_DATA, seed[7:0]);
        rd(`SSF_OFF_STATUS, 8'h00);
        chk("txData", {23'h0, seed[7:0]}, {23'h0, txData});
        repeat (60) @(posedge sys_clk);
        rd(`SSF_OFF_STATUS, 8'hc0);
        wr(`SSF_OFF_CTRL2, 8'h40);
        repeat (2) @(posedge sys_clk);
        chk("txDoneIrq", 32'h1, {31'h0, txDoneIrq});
        wr(`SSF_OFF_CTRL2, 8'h48);
        rd(`SSF_OFF_STATUS, 8'h80);
        chk("txDoneIrq", 32'h0, {31'h0, txDoneIrq});
        repeat (40) @(posedge sys_clk);
        rd(`SSF_OFF_STATUS, 8'hc0);
        wr(`SSF_OFF_CTRL2, 8'h49);
        rd(`SSF_OFF_STATUS, 8'h80);
        repeat (40) @(posedge sys_clk);
        rd(`SSF_OFF_STATUS, 8'h80);
        wr(`SSF_OFF_CTRL2, 8'h08);
        repeat (40) @(posedge sys_clk);
        rd(`SSF_OFF_STATUS, 8'hc0);
        // Error flags one at a time, parity last with checking off
        wr(`SSF_OFF_CTRL1, 8'h02);
        for (int i = 0; i < 5; i++) begin
            f = (i == 0) ? 3'b000 : (i == 4) ? 3'b001 : 3'b100 >> (i - 1);
            e = (i == 4) ? 8'he0 : 8'he0 | {5'h0, f};
            if (i == 4) wr(`SSF_OFF_CTRL1, 8'h00);
            seed = lfsr(seed);
            d = {2'b00, seed[6:0]};
            i_ssf_far_model.send_char(d, f[2], f[1], f[0], 1'b0);
            rd(`SSF_OFF_STATUS, e);
            rd(`SSF_OFF_DATA, d[7:0]);
            rd(`SSF_OFF_STATUS, 8'hc0);
            settle(d[7:0]);
        end
        chk("parityEnable", 32'h0, {31'h0, parityEnable});
        // Second character while the first is unread
        seed = lfsr(seed);
        d = {2'b00, seed[6:0]};
        i_ssf_far_model.send_char(d, 1'b0, 1'b0, 1'b0, 1'b0);
        i_ssf_far_model.send_char(~d, 1'b1, 1'b1, 1'b0, 1'b0);
        rd(`SSF_OFF_STATUS, 8'he8);
        rd(`SSF_OFF_DATA, d[7:0]);
        rd(`SSF_OFF_STATUS, 8'hc0);
        settle(d[7:0]);
        // Nine-bit character needs both reads
        wr(`SSF_OFF_CTRL1, 8'h14);
        wr(`SSF_OFF_CTRL2, 8'h28);
        chk("nineBitMode", 32'h1, {31'h0, nineBitMode});
        seed = lfsr(seed);
        d = {2'b10, seed[6:0]};
        i_ssf_far_model.send_char(d, 1'b0, 1'b0, 1'b0, 1'b1);
        rd(`SSF_OFF_STATUS, 8'he0);
        chk("rxFullIrq", 32'h1, {31'h0, rxFullIrq});
        rd(`SSF_OFF_DATA, d[7:0]);
        repeat (3) @(posedge sys_clk);
        chk("rxFullIrq", 32'h1, {31'h0, rxFullIrq});
        rd(`SSF_OFF_CTRL3, 8'h80);
        repeat (3) @(posedge sys_clk);
        chk("rxFullIrq", 32'h0, {31'h0, rxFullIrq});
        settle(d[7:0]);
        print_verdict();
    end
endmodule

`default_nettype wire
